// ### core/acs_sequencer.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Setting enable powers the converter up; clearing it powers it down.
// - Clearing enable mid-conversion aborts it at once with no result.
// - In free running mode one start write begins endless conversions.
// - First start after enabling, or start with enable, adds a dummy conversion.
// - Start bit reads one throughout a conversion.
// - Start bit clears on completion, one cycle before the result lands.
// - Start written while busy queues the next conversion right after.
// - With a dummy first, start stays one until the real one completes.
// - Writing zero to start changes nothing.
// - Three-bit channel field picks one of eight analog inputs.
// - Bandgap select with brown-out fuse converts the internal reference.
// - A new channel takes effect only after the running conversion.
// - Completion interrupt rises when the result becomes readable.
// - Free running: next conversion starts in the cycle the interrupt rises.
// - Channel change after that interrupt does not affect the started conversion.
module acs_sequencer import acs_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Fuse strap
    input wire logic brownout_detector_fuse,
    // Analog converter core
    output logic conv_power,
    output logic conv_start,
    output logic [ACS_CH_W-1:0] conv_channel,
    output logic conv_bandgap,
    output logic conv_tick,
    input wire logic conv_done,
    input wire logic [ACS_RES_W-1:0] conv_result,
    // Completion request
    output logic conv_done_irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic converter_enable;
        logic conversion_start;
        logic continuous_mode;
        logic conversion_done_flag;
        logic conversion_done_irq_en;
        logic [ACS_PS_W-1:0] divider;
        logic bandgap_select;
        logic [ACS_CH_W-1:0] channel_select_field;
        logic need_init;
        logic pending;
        acs_state_e state;
        logic [ACS_CH_W-1:0] act_chan;
        logic act_bg;
        logic [ACS_RES_W-1:0] hold;
        logic [ACS_RES_W-1:0] result;
        logic [ACS_PRESC_W-1:0] presc;
        logic tick;
        logic cstart;
    } acs_core_s;

    localparam acs_core_s ACS_CORE_RESET = '0;

    acs_core_s r;
    acs_core_s n;

    logic wr_stb;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic rd_stb;
    logic [7:0] rd_idx;
    logic [31:0] rd_data;
    logic start_wr;

    // ************************************************************
    // Bus slave
    // ************************************************************
    acs_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_stb(wr_stb),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_stb(rd_stb),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    // ************************************************************
    // Conversion launch
    // ************************************************************
    // Channel and reference are frozen here, so later writes wait
    function automatic acs_core_s acs_launch(acs_core_s s, logic dummy, logic fuse);
        acs_core_s t;
        t = s;
        t.state = dummy ? ACS_DUMMY : ACS_CONV;
        t.need_init = 1'b0;
        t.conversion_start = 1'b1;
        t.cstart = 1'b1;
        t.act_chan = s.channel_select_field;
        t.act_bg = s.bandgap_select && fuse;
        return t;
    endfunction : acs_launch

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n = r;
        n.cstart = 1'b0;
        n.tick = 1'b0;
        start_wr = 1'b0;

        // Prescaler runs only while powered
        if (r.converter_enable) begin
            if (r.presc >= acs_presc_top(r.divider)) begin
                n.presc = '0;
                n.tick = 1'b1;
            end else begin
                n.presc = r.presc + ACS_PRESC_W'(1);
            end
        end else begin
            n.presc = '0;
        end

        // Register writes
        if (wr_stb && wr_idx == ACS_IDX_CTRL) begin
            n.converter_enable = wr_data[ACS_CTRL_EN];
            n.continuous_mode = wr_data[ACS_CTRL_FREE];
            n.conversion_done_irq_en = wr_data[ACS_CTRL_IE];
            n.divider = wr_data[ACS_CTRL_PS_LSB +: ACS_PS_W];
            if (wr_data[ACS_CTRL_FLAG]) begin
                n.conversion_done_flag = 1'b0;
            end
            if (!r.converter_enable && wr_data[ACS_CTRL_EN]) begin
                n.need_init = 1'b1;
            end
            // A zero in the start bit is simply not a request
            start_wr = wr_data[ACS_CTRL_START];
        end
        if (wr_stb && wr_idx == ACS_IDX_MUX) begin
            n.bandgap_select = wr_data[ACS_MUX_BG];
            n.channel_select_field = wr_data[ACS_MUX_CH_LSB +: ACS_CH_W];
        end

        // Sequencer
        unique case (r.state)
            ACS_IDLE: begin
                if (start_wr && n.converter_enable) begin
                    n = acs_launch(n, n.need_init, brownout_detector_fuse);
                end
            end
            ACS_DUMMY: begin
                if (start_wr) begin
                    n.pending = 1'b1;
                end
                // Dummy result is thrown away; the real one follows at once
                if (conv_done) begin
                    n = acs_launch(n, 1'b0, brownout_detector_fuse);
                end
            end
            ACS_CONV: begin
                if (start_wr) begin
                    n.pending = 1'b1;
                end
                if (conv_done) begin
                    n.conversion_start = 1'b0;
                    n.hold = conv_result;
                    n.state = ACS_WRITE;
                end
            end
            ACS_WRITE: begin
                n.result = r.hold;
                n.conversion_done_flag = 1'b1;
                if (n.continuous_mode || r.pending || start_wr) begin
                    n = acs_launch(n, 1'b0, brownout_detector_fuse);
                    n.pending = 1'b0;
                end else begin
                    n.state = ACS_IDLE;
                end
            end
        endcase

        // Power-down drops any conversion in flight and its result
        if (!n.converter_enable) begin
            n.state = ACS_IDLE;
            n.conversion_start = 1'b0;
            n.pending = 1'b0;
            n.cstart = 1'b0;
            n.tick = 1'b0;
            n.need_init = 1'b0;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= ACS_CORE_RESET;
        end else begin
            r <= n;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_comb begin
        rd_data = '0;
        if (rd_stb) begin
            unique case (rd_idx)
                ACS_IDX_CTRL: begin
                    rd_data[ACS_CTRL_EN] = r.converter_enable;
                    rd_data[ACS_CTRL_START] = r.conversion_start;
                    rd_data[ACS_CTRL_FREE] = r.continuous_mode;
                    rd_data[ACS_CTRL_FLAG] = r.conversion_done_flag;
                    rd_data[ACS_CTRL_IE] = r.conversion_done_irq_en;
                    rd_data[ACS_CTRL_PS_LSB +: ACS_PS_W] = r.divider;
                end
                ACS_IDX_MUX: begin
                    rd_data[ACS_MUX_BG] = r.bandgap_select;
                    rd_data[ACS_MUX_CH_LSB +: ACS_CH_W] = r.channel_select_field;
                end
                ACS_IDX_RESULT: begin
                    rd_data[ACS_RES_W-1:0] = r.result;
                end
                default: begin
                    rd_data = '0;
                end
            endcase
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign conv_power = r.converter_enable;
    assign conv_start = r.cstart;
    assign conv_channel = r.act_chan;
    assign conv_bandgap = r.act_bg;
    assign conv_tick = r.tick;
    assign conv_done_irq = r.conversion_done_flag && r.conversion_done_irq_en;

endmodule : acs_sequencer

// ### core/acs_pkg.sv
package acs_pkg;

    // ************************************************************
    // Register map (index, byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] ACS_IDX_RESULT = 8'h04;
    localparam logic [7:0] ACS_IDX_CTRL = 8'h06;
    localparam logic [7:0] ACS_IDX_MUX = 8'h07;
    localparam int ACS_IDX_LSB = 2;
    localparam int ACS_IDX_MSB = 9;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int ACS_CTRL_EN = 7;
    localparam int ACS_CTRL_START = 6;
    localparam int ACS_CTRL_FREE = 5;
    localparam int ACS_CTRL_FLAG = 4;
    localparam int ACS_CTRL_IE = 3;
    localparam int ACS_CTRL_PS_LSB = 0;
    localparam int ACS_MUX_BG = 6;
    localparam int ACS_MUX_CH_LSB = 0;
    localparam int ACS_PS_W = 3;
    localparam int ACS_CH_W = 3;
    localparam int ACS_RES_W = 10;
    localparam int ACS_PRESC_W = 8;

    // ************************************************************
    // Reset values and bus answers
    // ************************************************************
    localparam logic [7:0] ACS_CTRL_RESET = 8'h00;
    localparam logic [7:0] ACS_MUX_RESET = 8'h00;
    localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
    localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_DUMMY,
        ACS_CONV,
        ACS_WRITE
    } acs_state_e;

    typedef struct packed {
        logic aw_full;
        logic [31:0] awaddr;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } acs_axil_s;

    localparam acs_axil_s ACS_AXIL_RESET = '0;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic acs_hit(logic [31:0] addr);
        logic [7:0] idx;
        idx = addr[ACS_IDX_MSB:ACS_IDX_LSB];
        return (addr[31:ACS_IDX_MSB+1] == '0) && (addr[ACS_IDX_LSB-1:0] == '0) &&
            (idx == ACS_IDX_RESULT || idx == ACS_IDX_CTRL || idx == ACS_IDX_MUX);
    endfunction : acs_hit

    // Divider is 2 << ps system clocks per converter tick
    function automatic logic [ACS_PRESC_W-1:0] acs_presc_top(logic [ACS_PS_W-1:0] ps);
        logic [ACS_PRESC_W:0] d;
        d = (ACS_PRESC_W+1)'(2) << ps;
        return ACS_PRESC_W'(d - (ACS_PRESC_W+1)'(1));
    endfunction : acs_presc_top

endpackage : acs_pkg

// ### core/acs_axil_slave.sv
`timescale 1ns/1ps
module acs_axil_slave import acs_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address and data
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register side
    output logic wr_stb,
    output logic [7:0] wr_idx,
    output logic [7:0] wr_data,
    output logic rd_stb,
    output logic [7:0] rd_idx,
    input wire logic [31:0] rd_data
);

    acs_axil_s r;
    acs_axil_s n;

    assign s_axi_awready = !r.aw_full && !r.bvalid;
    assign s_axi_wready = !r.w_full && !r.bvalid;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign wr_idx = r.awaddr[ACS_IDX_MSB:ACS_IDX_LSB];
    assign wr_data = r.wdata[7:0];
    assign rd_idx = s_axi_araddr[ACS_IDX_MSB:ACS_IDX_LSB];

    always_comb begin
        n = r;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_full = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_full = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        // Writable registers live in lane 0 only; other lanes are ignored
        if (r.aw_full && r.w_full) begin
            wr_stb = acs_hit(r.awaddr) && r.wstrb[0];
            n.aw_full = 1'b0;
            n.w_full = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = acs_hit(r.awaddr) ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rd_stb = acs_hit(s_axi_araddr);
            n.rvalid = 1'b1;
            n.rdata = acs_hit(s_axi_araddr) ? rd_data : '0;
            n.rresp = acs_hit(s_axi_araddr) ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
        end
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= ACS_AXIL_RESET;
        end else begin
            r <= n;
        end
    end

endmodule : acs_axil_slave

// ### verification/acs_monitor.sv
`timescale 1ns/1ps
module acs_monitor import acs_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Converter side
    input wire logic brownout_detector_fuse,
    input wire logic conv_power,
    input wire logic conv_start,
    input wire logic [ACS_CH_W-1:0] conv_channel,
    input wire logic conv_bandgap,
    input wire logic conv_tick,
    input wire logic conv_done,
    input wire logic conv_done_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ************************************************************
    // Checks
    // ************************************************************
    power_gate_a: assert property (
        !conv_power |-> !conv_start && !conv_tick) else $error("activity while off");
    start_pulse_a: assert property (
        conv_start |=> !conv_start) else $error("launch longer than one cycle");
    chan_hold_a: assert property (
        !conv_start |-> $stable(conv_channel)) else $error("channel moved mid conversion");
    irq_cause_a: assert property (
        $rose(conv_done_irq) |-> $past(conv_done, 2) || $rose(s_axi_bvalid))
        else $error("irq rose without a result");
    bg_fuse_a: assert property (
        conv_start && conv_bandgap |-> $past(brownout_detector_fuse))
        else $error("bandgap without fuse");
    tick_pulse_a: assert property (
        conv_tick |=> !conv_tick) else $error("tick too long");
    rd_lat_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    wr_lat_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off");
    b_drop_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response repeated");
    cover property (conv_start && conv_done_irq);
    cover property ($rose(conv_done_irq));
    cover property (conv_start && conv_bandgap);
endmodule : acs_monitor

// ### verification/acs_core_model.sv
`timescale 1ns/1ps
module acs_core_model import acs_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Converter control
    input wire logic conv_power,
    input wire logic conv_start,
    input wire logic [ACS_CH_W-1:0] conv_channel,
    input wire logic conv_bandgap,
    input wire logic [7:0] lat,
    // Result
    output logic conv_done,
    output logic [ACS_RES_W-1:0] conv_result
);
    int cnt = 0;
    logic [ACS_RES_W-1:0] held = '0;
    initial begin
        conv_done = 1'b0;
        conv_result = '0;
    end
    always @(posedge aclk) begin
        conv_done <= 1'b0;
        // Result lines toggle outside the done pulse
        conv_result <= ~conv_result;
        if (!aresetn || !conv_power) begin
            cnt <= 0;
        end else if (conv_start) begin
            cnt <= int'(lat);
            held <= {conv_bandgap, 6'h00, conv_channel};
        end else if (cnt == 1) begin
            cnt <= 0;
            conv_done <= 1'b1;
            conv_result <= held;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : acs_core_model

// ### verification/acs_sequencer_tb.sv
`timescale 1ns/1ps
module acs_sequencer_tb import acs_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, brownout_detector_fuse = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic conv_power, conv_start, conv_bandgap, conv_tick, conv_done, conv_done_irq;
    logic [2:0] conv_channel;
    logic [9:0] conv_result;
    logic [7:0] lat = 8'h14;
    int failures = 0, checks = 0, nstart = 0, ndone = 0, d0, s0;

    initial forever #2.5 aclk = ~aclk;
    // Counted at the rising edge, so waits polled on the falling edge never race it
    always @(posedge aclk) begin
        if (conv_start) nstart++;
        if (conv_done) ndone++;
    end
    acs_sequencer uut (.*);
    acs_core_model core (.*);

    // ************************************************************
    // Bus and compare tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tmo(input logic bad);
        if (bad) begin
            failures++;
            $display("wait timed out");
            report_and_stop();
        end
    endtask : tmo
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
        int n;
        logic ta, tw;
        @(posedge aclk);
        s_axi_awaddr <= {22'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        ta = 1'b0;
        tw = 1'b0;
        n = 0;
        while (!(ta && tw) && n < 50) begin
            @(negedge aclk);
            ta = ta || s_axi_awready;
            tw = tw || s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            n++;
        end
        do begin @(negedge aclk); n++; end while (!s_axi_bvalid && n < 100);
        tmo(n >= 100);
        chk("bresp", 32'(er), 32'(s_axi_bresp));
        @(posedge aclk);
    endtask : wr
    task automatic rd(input string what, input logic [7:0] i, input logic [31:0] exp,
                      input logic [1:0] er = 2'h0);
        int n;
        @(posedge aclk);
        s_axi_araddr <= {22'h0, i, 2'h0};
        s_axi_arvalid <= 1'b1;
        n = 0;
        do begin @(negedge aclk); n++; end while (!s_axi_arready && n < 50);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do begin @(negedge aclk); n++; end while (!s_axi_rvalid && n < 100);
        tmo(n >= 100);
        chk(what, exp, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        @(posedge aclk);
    endtask : rd
    // Result lands one edge after the taken done pulse
    task automatic waitd(input int t, input int extra);
        int n;
        n = 0;
        while (ndone < t && n < 500) begin @(negedge aclk); n++; end
        tmo(n >= 500);
        repeat (extra) begin
            @(posedge aclk);
            @(negedge aclk);
        end
    endtask : waitd
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs;
        rd("ctrl", ACS_IDX_CTRL, 32'h0);
        rd("mux", ACS_IDX_MUX, 32'h0);
        rd("result", ACS_IDX_RESULT, 32'h0);
        rd("unmapped", 8'h05, 32'h0, ACS_RESP_SLVERR);
        wr(8'h05, 8'hff, ACS_RESP_SLVERR);
        wr(ACS_IDX_MUX, 8'h45);
        rd("mux", ACS_IDX_MUX, 32'h45);
        $display("test regs done");
    endtask : t_regs
    task automatic t_dummy;
        {d0, s0} = {ndone, nstart};
        wr(ACS_IDX_CTRL, 8'hc8);
        chk("power", 32'h1, 32'(conv_power));
        rd("busy", ACS_IDX_CTRL, 32'hc8);
        waitd(d0 + 1, 0);
        rd("after dummy", ACS_IDX_CTRL, 32'hc8);
        waitd(d0 + 2, 2);
        chk("irq", 32'h1, 32'(conv_done_irq));
        chk("launches", 32'(s0 + 2), 32'(nstart));
        rd("done", ACS_IDX_CTRL, 32'h98);
        rd("result", ACS_IDX_RESULT, 32'h005);
        wr(ACS_IDX_CTRL, 8'h80);
        chk("irq masked", 32'h0, 32'(conv_done_irq));
        wr(ACS_IDX_CTRL, 8'h98);
        rd("cleared", ACS_IDX_CTRL, 32'h88);
        $display("test dummy done");
    endtask : t_dummy
    task automatic t_chan;
        lat <= 8'h1e;
        brownout_detector_fuse <= 1'b1;
        wr(ACS_IDX_MUX, 8'h42);
        {d0, s0} = {ndone, nstart};
        wr(ACS_IDX_CTRL, 8'hc8);
        wr(ACS_IDX_MUX, 8'h03);
        chk("channel", 32'h2, 32'(conv_channel));
        chk("bandgap", 32'h1, 32'(conv_bandgap));
        wr(ACS_IDX_CTRL, 8'h88);
        rd("start kept", ACS_IDX_CTRL, 32'hc8);
        waitd(d0 + 1, 2);
        rd("result", ACS_IDX_RESULT, 32'h202);
        rd("single", ACS_IDX_CTRL, 32'h98);
        chk("launches", 32'(s0 + 1), 32'(nstart));
        wr(ACS_IDX_CTRL, 8'h98);
        $display("test channel done");
    endtask : t_chan
    task automatic t_queue;
        {d0, s0} = {ndone, nstart};
        wr(ACS_IDX_CTRL, 8'hc8);
        wr(ACS_IDX_CTRL, 8'hc8);
        waitd(d0 + 1, 1);
        chk("relaunch", 32'h1, 32'(conv_start));
        chk("channel", 32'h3, 32'(conv_channel));
        waitd(d0 + 2, 2);
        chk("launches", 32'(s0 + 2), 32'(nstart));
        rd("done", ACS_IDX_CTRL, 32'h98);
        wr(ACS_IDX_CTRL, 8'h98);
        $display("test queue done");
    endtask : t_queue
    task automatic t_free;
        {d0, s0} = {ndone, nstart};
        wr(ACS_IDX_CTRL, 8'he8);
        waitd(d0 + 1, 1);
        chk("free", 32'h1, 32'(conv_start && conv_done_irq));
        wr(ACS_IDX_MUX, 8'h01);
        chk("old channel", 32'h3, 32'(conv_channel));
        waitd(d0 + 2, 1);
        chk("new channel", 32'h1, 32'(conv_channel));
        wr(ACS_IDX_CTRL, 8'h18);
        s0 = nstart;
        repeat (40) @(posedge aclk);
        chk("power", 32'h0, 32'(conv_power));
        chk("launches", 32'(s0), 32'(nstart));
        rd("aborted", ACS_IDX_CTRL, 32'h08);
        rd("no result", ACS_IDX_RESULT, 32'h003);
        lat <= 8'h01;
        d0 = ndone;
        wr(ACS_IDX_CTRL, 8'hc0);
        waitd(d0 + 2, 2);
        rd("prompt", ACS_IDX_CTRL, 32'h90);
        chk("no irq", 32'h0, 32'(conv_done_irq));
        $display("test free done");
    endtask : t_free

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_dummy();
        t_chan();
        t_queue();
        t_free();
        report_and_stop();
    end
endmodule : acs_sequencer_tb

bind acs_sequencer acs_monitor mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .brownout_detector_fuse, .conv_power, .conv_start,
    .conv_channel, .conv_bandgap, .conv_tick, .conv_done, .conv_done_irq);
